// ### shared/rsu_pkg.sv
// constants and types shared by the random seed unit
package rsu_pkg;
	localparam int DATA_W = 32;
	localparam logic [31:0] LEAF_BASIC = 32'h0000_0001;
	localparam logic [31:0] LEAF_EXT = 32'h0000_0007;
	localparam logic [31:0] SUBLEAF_ZERO = 32'h0000_0000;
	localparam int RAND_FEATURE_BIT = 30;
	localparam int SEED_FEATURE_BIT = 18;
	localparam int REP_LIMIT = 12;
	localparam int RESEED_INTERVAL = 64;
	localparam logic [31:0] GEN_RESET_STATE = 32'h1357_9BDF;
	localparam logic [31:0] GEN_FALLBACK = 32'h2468_ACE1;
	localparam int XS_A = 13;
	localparam int XS_B = 17;
	localparam int XS_C = 5;

	typedef enum logic [1:0] {
		FLAG_NONE = 2'h0,
		FLAG_SET = 2'h1,
		FLAG_CLR = 2'h2,
		FLAG_CMP = 2'h3
	} rsu_flag_op_t;

	typedef enum logic {
		GEN_UNSEEDED = 1'b0,
		GEN_READY = 1'b1
	} rsu_gen_mode_t;
endpackage

// ### shared/rsu_seed_if.sv
// seed word handover from entropy source to the generator logic
`timescale 1ns/10ps
interface rsu_seed_if #(parameter int W = 32);
	logic valid;
	logic bad;
	logic [W-1:0] data;
	logic take;
	modport src (output valid, output bad, output data, input take);
	modport snk (input valid, input bad, input data, output take);
endinterface

// ### verilog/rsu_entropy.sv
// non-deterministic entropy source with repetition health test
`timescale 1ns/10ps
module rsu_entropy #(
	parameter int W = 32,
	parameter int LIMIT = rsu_pkg::REP_LIMIT
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_noise,
	rsu_seed_if.src seed
);
	localparam int CW = $clog2(W + 1);
	localparam int RW = $clog2(LIMIT + 1);
	if (LIMIT < 2 || W < 2) begin : g_bad
		$error("rsu_entropy: LIMIT and W must be at least 2");
	end

	logic sync1, sync2, last_bit, word_bad, out_valid, out_bad;
	logic [W-1:0] shreg, out_data;
	logic [CW-1:0] nbits;
	logic [RW-1:0] run;
	logic next_last_bit, next_word_bad, next_out_valid, next_out_bad;
	logic [W-1:0] next_shreg, next_out_data;
	logic [CW-1:0] next_nbits;
	logic [RW-1:0] next_run;

	assign seed.valid = out_valid;
	assign seed.bad = out_bad;
	assign seed.data = out_data;

	always_comb begin
		next_last_bit = sync2;
		next_shreg = {shreg[W-2:0], sync2};
		next_word_bad = word_bad;
		next_nbits = nbits + CW'(1);
		next_out_valid = out_valid;
		next_out_bad = out_bad;
		next_out_data = out_data;
		next_run = RW'(1);
		if (sync2 == last_bit) begin
			next_run = (run == RW'(LIMIT)) ? run : run + RW'(1);
			if (run >= RW'(LIMIT - 1)) begin
				next_word_bad = 1'b1;
			end
		end
		if (seed.take) begin
			next_out_valid = 1'b0;
		end
		// a finished word waits only while the slot is free; otherwise it is dropped
		if (nbits == CW'(W - 1)) begin
			next_nbits = '0;
			next_word_bad = 1'b0;
			if (!next_out_valid) begin
				next_out_valid = 1'b1;
				next_out_data = next_shreg;
				next_out_bad = word_bad || (sync2 == last_bit && run >= RW'(LIMIT - 1));
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			last_bit <= 1'b0;
			shreg <= '0;
			word_bad <= 1'b1;
			nbits <= '0;
			run <= '0;
			out_valid <= 1'b0;
			out_bad <= 1'b0;
			out_data <= '0;
		end else begin
			sync1 <= i_noise;
			sync2 <= sync1;
			last_bit <= next_last_bit;
			shreg <= next_shreg;
			word_bad <= next_word_bad;
			nbits <= next_nbits;
			run <= next_run;
			out_valid <= next_out_valid;
			out_bad <= next_out_bad;
			out_data <= next_out_data;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	// word_bad is cleared whenever a word finishes, slot full or free, so only mid-word runs are checked
	chk_run_marks_bad: assert property (
		(sync2 == last_bit && run >= RW'(LIMIT - 1) && nbits != CW'(W - 1)) |=> word_bad)
		else $error("long run not marked bad");
endmodule // rsu_entropy

// ### verilog/rsu_top.sv
// random number and seed supply for several cores
`timescale 1ns/10ps
module rsu_top #(
	parameter int NCORE = 4,
	parameter int RESEED_INTERVAL = rsu_pkg::RESEED_INTERVAL
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_noise,
	input wire logic [NCORE-1:0] i_rand_req,
	input wire logic [NCORE-1:0] i_seed_req,
	input wire rsu_pkg::rsu_flag_op_t [NCORE-1:0] i_flag_op,
	input wire logic i_id_req,
	input wire logic [31:0] i_id_leaf,
	input wire logic [31:0] i_id_subleaf,
	output logic [NCORE-1:0] o_ack,
	output logic [NCORE-1:0][rsu_pkg::DATA_W-1:0] o_data,
	output logic [NCORE-1:0] o_carry,
	output logic o_id_ack,
	output logic [31:0] o_id_base,
	output logic [31:0] o_id_count
);
	localparam int W = rsu_pkg::DATA_W;
	localparam int IW = (NCORE > 1) ? $clog2(NCORE) : 1;
	localparam int KW = $clog2(RESEED_INTERVAL + 1);
	if (NCORE < 1 || NCORE > 16 || RESEED_INTERVAL < 1 || RESEED_INTERVAL > 4096) begin : g_bad
		$error("rsu_top: NCORE must be 1..16 and RESEED_INTERVAL 1..4096");
	end

	rsu_seed_if #(.W(W)) seed_bus ();

	rsu_entropy #(.W(W), .LIMIT(rsu_pkg::REP_LIMIT)) u_entropy (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_noise(i_noise),
		.seed(seed_bus.src)
	);

	rsu_pkg::rsu_gen_mode_t gen_mode, next_gen_mode;
	logic [W-1:0] gen_state, next_gen_state, xs;
	logic gen_avail, next_gen_avail;
	logic [KW-1:0] reseed_cnt, next_reseed_cnt;
	logic [NCORE-1:0] next_ack, next_carry;
	logic [NCORE-1:0][W-1:0] next_data;
	logic next_id_ack;
	logic [31:0] next_id_base, next_id_count;
	logic rand_have, seed_have, rand_give, seed_give, seed_due, reseed_take, seed_serve;
	logic [IW-1:0] rand_win, seed_win;

	// lowest core index wins; losers are still answered, just empty
	always_comb begin
		rand_have = 1'b0;
		seed_have = 1'b0;
		rand_win = '0;
		seed_win = '0;
		for (int i = NCORE - 1; i >= 0; i--) begin
			if (i_rand_req[i]) begin
				rand_have = 1'b1;
				rand_win = IW'(i);
			end
			if (i_seed_req[i] && !i_rand_req[i]) begin
				seed_have = 1'b1;
				seed_win = IW'(i);
			end
		end
	end

	always_comb begin
		xs = gen_state ^ (gen_state << rsu_pkg::XS_A);
		xs = xs ^ (xs >> rsu_pkg::XS_B);
		xs = xs ^ (xs << rsu_pkg::XS_C);
		seed_due = (gen_mode == rsu_pkg::GEN_UNSEEDED) || (reseed_cnt == '0);
		reseed_take = seed_due && seed_bus.valid;
		rand_give = rand_have && gen_avail && !seed_due;
		// reseeding has first claim on entropy words
		seed_serve = seed_have && seed_bus.valid && !seed_due;
		seed_give = seed_serve && !seed_bus.bad;
		seed_bus.take = reseed_take || seed_serve;

		next_gen_mode = gen_mode;
		next_gen_state = gen_state;
		next_gen_avail = gen_avail;
		next_reseed_cnt = reseed_cnt;
		// one value per two cycles shared by all cores
		if (rand_give) begin
			next_gen_avail = 1'b0;
			next_reseed_cnt = reseed_cnt - KW'(1);
		end else if (!gen_avail) begin
			next_gen_state = xs;
			next_gen_avail = 1'b1;
		end
		if (reseed_take && !seed_bus.bad) begin
			next_gen_state = ((gen_state ^ seed_bus.data) == '0) ?
				rsu_pkg::GEN_FALLBACK : (gen_state ^ seed_bus.data);
			next_gen_mode = rsu_pkg::GEN_READY;
			next_gen_avail = 1'b0;
			next_reseed_cnt = KW'(RESEED_INTERVAL);
		end

		for (int i = 0; i < NCORE; i++) begin
			next_ack[i] = i_rand_req[i] || i_seed_req[i];
			next_data[i] = '0;
			case (i_flag_op[i])
				rsu_pkg::FLAG_SET: next_carry[i] = 1'b1;
				rsu_pkg::FLAG_CLR: next_carry[i] = 1'b0;
				rsu_pkg::FLAG_CMP: next_carry[i] = !o_carry[i];
				default: next_carry[i] = o_carry[i];
			endcase
			if (rand_give && rand_win == IW'(i)) begin
				next_data[i] = gen_state;
				next_carry[i] = 1'b1;
			end else if (seed_give && seed_win == IW'(i)) begin
				next_data[i] = seed_bus.data;
				next_carry[i] = 1'b1;
			end else if (next_ack[i]) begin
				next_carry[i] = 1'b0;
			end
		end

		next_id_ack = i_id_req;
		next_id_base = '0;
		next_id_count = '0;
		if (i_id_req && i_id_leaf == rsu_pkg::LEAF_BASIC) begin
			next_id_count[rsu_pkg::RAND_FEATURE_BIT] = 1'b1;
		end
		if (i_id_req && i_id_leaf == rsu_pkg::LEAF_EXT &&
			i_id_subleaf == rsu_pkg::SUBLEAF_ZERO) begin
			next_id_base[rsu_pkg::SEED_FEATURE_BIT] = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			gen_mode <= rsu_pkg::GEN_UNSEEDED;
			gen_state <= rsu_pkg::GEN_RESET_STATE;
			gen_avail <= 1'b0;
			reseed_cnt <= '0;
			o_ack <= '0;
			o_data <= '0;
			o_carry <= '0;
			o_id_ack <= 1'b0;
			o_id_base <= '0;
			o_id_count <= '0;
		end else begin
			gen_mode <= next_gen_mode;
			gen_state <= next_gen_state;
			gen_avail <= next_gen_avail;
			reseed_cnt <= next_reseed_cnt;
			o_ack <= next_ack;
			o_data <= next_data;
			o_carry <= next_carry;
			o_id_ack <= next_id_ack;
			o_id_base <= next_id_base;
			o_id_count <= next_id_count;
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	chk_id_rand_bit: assert property (
		(i_id_req && i_id_leaf == rsu_pkg::LEAF_BASIC)
		|=> (o_id_ack && o_id_count[rsu_pkg::RAND_FEATURE_BIT] && o_id_base == '0))
		else $error("read-random feature bit missing");
	chk_id_seed_bit: assert property (
		(i_id_req && i_id_leaf == rsu_pkg::LEAF_EXT && i_id_subleaf == rsu_pkg::SUBLEAF_ZERO)
		|=> (o_id_ack && o_id_base[rsu_pkg::SEED_FEATURE_BIT] && o_id_count == '0))
		else $error("read-seed feature bit missing");
	chk_reseed_gate: assert property (
		(seed_due && |i_rand_req) |=> ((o_carry & $past(i_rand_req)) == '0))
		else $error("value given while reseed due");
	chk_seed_direct: assert property (
		(seed_give && seed_win == '0) |=> (o_carry[0] && o_data[0] == $past(seed_bus.data)))
		else $error("seed word not passed to core 0");
	chk_unseeded_empty: assert property (
		(gen_mode == rsu_pkg::GEN_UNSEEDED && i_rand_req[0]) |=> (o_ack[0] && !o_carry[0]))
		else $error("unseeded generator gave data");
	chk_bad_seed_empty: assert property (
		(seed_serve && seed_bus.bad && seed_win == '0) |=> (!o_carry[0] && o_data[0] == '0))
		else $error("bad seed word delivered");
	chk_all_answered: assert property (
		(|(i_rand_req | i_seed_req)) |=> ((o_ack & $past(i_rand_req | i_seed_req))
		== $past(i_rand_req | i_seed_req)))
		else $error("request not answered next cycle");
	chk_rand_empty: assert property (
		(i_rand_req[0] && !(rand_give && rand_win == '0))
		|=> (o_ack[0] && !o_carry[0] && o_data[0] == '0))
		else $error("empty read-random not reported");
	chk_rand_value: assert property (
		(rand_give && rand_win == '0) |=> (o_carry[0] && o_data[0] == $past(gen_state)))
		else $error("read-random value lost");
	chk_seed_missing: assert property (
		(i_seed_req[0] && !i_rand_req[0] && !seed_bus.valid) |=> (o_ack[0] && !o_carry[0]))
		else $error("empty read-seed not reported");
	chk_flag_flip: assert property (
		(i_flag_op[0] == rsu_pkg::FLAG_CMP && !i_rand_req[0] && !i_seed_req[0])
		|=> (o_carry[0] != $past(o_carry[0])))
		else $error("carry complement failed");

	cov_rand_ok: cover property (rand_give ##1 o_carry[0]);
	cov_seed_ok: cover property (seed_give);
	cov_seed_bad: cover property (seed_serve && seed_bus.bad);
	cov_contention: cover property ($countones(i_rand_req) >= 2 && rand_give);
endmodule // rsu_top

// ### verif/rsu_noise_model.sv
// noise pin model: an lfsr bit stream, or a stuck level for the health test
`timescale 1ns/10ps
module rsu_noise_model (
	input wire logic i_clk_sys,
	input wire logic i_stuck,
	output logic o_noise
);
	logic [7:0] lfsr = 8'hA5;
	// short lfsr keeps runs of equal bits below the repetition limit
	always @(posedge i_clk_sys) begin
		#1 lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
	end
	// stuck level is a failed source the design must flag
	assign o_noise = i_stuck ? 1'b1 : lfsr[7];
endmodule // rsu_noise_model

// ### verif/rsu_top_bench.sv
// self-checking bench for the random seed unit
`timescale 1ns/10ps
module rsu_top_bench;
	localparam int NC = 4;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic stuck = 1'b1;
	logic noise;
	logic [NC-1:0] i_rand_req = '0;
	logic [NC-1:0] i_seed_req = '0;
	rsu_pkg::rsu_flag_op_t [NC-1:0] i_flag_op;
	logic i_id_req = 1'b0;
	logic [31:0] i_id_leaf = 32'h0;
	logic [31:0] i_id_subleaf = 32'h0;
	logic [NC-1:0] o_ack;
	logic [NC-1:0][31:0] o_data;
	logic [NC-1:0] o_carry;
	logic o_id_ack;
	logic [31:0] o_id_base;
	logic [31:0] o_id_count;
	int miscompares = 0;
	int tests_run = 0;
	logic cy;
	logic [31:0] dv;

	always #25 i_clk_sys = ~i_clk_sys;

	rsu_noise_model i_noise_model (.i_clk_sys(i_clk_sys), .i_stuck(stuck), .o_noise(noise));

	// small reseed interval so reseeding happens often in a short run
	rsu_top #(.NCORE(NC), .RESEED_INTERVAL(2)) i_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_noise(noise),
		.i_rand_req(i_rand_req), .i_seed_req(i_seed_req), .i_flag_op(i_flag_op),
		.i_id_req(i_id_req), .i_id_leaf(i_id_leaf), .i_id_subleaf(i_id_subleaf),
		.o_ack(o_ack), .o_data(o_data), .o_carry(o_carry), .o_id_ack(o_id_ack),
		.o_id_base(o_id_base), .o_id_count(o_id_count)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic tick();
		@(posedge i_clk_sys);
		#1;
	endtask

	task automatic issue(input int c, input bit sd);
		tick();
		if (sd) i_seed_req[c] = 1'b1;
		else i_rand_req[c] = 1'b1;
		tick();
		i_rand_req = '0;
		i_seed_req = '0;
		check(o_ack[c], 1'b1); // answer never stalls
		cy = o_carry[c];
		dv = o_data[c];
		if (cy !== 1'b1) check(dv, 32'h0); // zero when empty
	endtask

	task automatic retry(input int c, input bit sd, input int bound);
		int n;
		n = 0;
		cy = 1'b0;
		while (cy !== 1'b1 && n < bound) begin
			issue(c, sd);
			n++;
		end
		if (cy !== 1'b1) begin
			miscompares++;
			$display("Error at %0t: no data after retries", $time);
			complete_run();
		end
	endtask

	task automatic id_query(input logic [31:0] leaf, sub, base, count);
		tick();
		i_id_req = 1'b1;
		i_id_leaf = leaf;
		i_id_subleaf = sub;
		tick();
		i_id_req = 1'b0;
		check(o_id_ack, 1'b1); // answer next cycle
		check(o_id_base, base); // seed support bit
		check(o_id_count, count); // random support bit
	endtask

	task automatic s_ident();
		id_query(rsu_pkg::LEAF_BASIC, 32'h0, 32'h0, 32'h1 << rsu_pkg::RAND_FEATURE_BIT);
		id_query(rsu_pkg::LEAF_EXT, rsu_pkg::SUBLEAF_ZERO,
			32'h1 << rsu_pkg::SEED_FEATURE_BIT, 32'h0);
		id_query(rsu_pkg::LEAF_EXT, 32'h1, 32'h0, 32'h0);
		id_query(32'h2, 32'h0, 32'h0, 32'h0);
	endtask

	task automatic s_stuck();
		repeat (80) tick();
		issue(0, 1'b0);
		check(cy, 1'b0); // bad words give empty
		issue(1, 1'b1);
		check(cy, 1'b0); // reseed claims words first
	endtask

	task automatic s_good();
		stuck = 1'b0;
		retry(0, 1'b0, 100);
		check(32'(dv == 32'h0), 32'h0); // seeded value
		tick();
		i_rand_req = 4'h3;
		tick();
		check(o_ack[1:0], 2'h3); // both cores answered
		check(32'(o_carry[1:0] == 2'h3), 32'h0); // one shared supply
		tick();
		i_rand_req = '0;
		check(o_carry[1:0], 2'h0); // back to back runs dry
		check(o_data[1], 32'h0); // zero when empty
	endtask

	task automatic s_seed();
		retry(0, 1'b1, 200);
		check(cy, 1'b1); // seed with data
		issue(0, 1'b1);
		check(cy, 1'b0); // slot already drained
	endtask

	// generator stays seeded while the source fails, so the seed path meets a bad word
	task automatic s_bad_seed();
		stuck = 1'b1;
		repeat (40) tick();
		issue(0, 1'b1);
		repeat (40) tick();
		issue(0, 1'b1);
		check(cy, 1'b0); // bad word consumed, not given
		issue(0, 1'b0);
		check(cy, 1'b1); // generator still seeded
		stuck = 1'b0;
	endtask

	task automatic flag(input rsu_pkg::rsu_flag_op_t op, input logic exp);
		tick();
		i_flag_op[0] = op;
		tick();
		i_flag_op[0] = rsu_pkg::FLAG_NONE;
		check(o_carry[0], exp); // direct carry ops
	endtask

	task automatic s_flags();
		flag(rsu_pkg::FLAG_SET, 1'b1);
		flag(rsu_pkg::FLAG_CLR, 1'b0);
		flag(rsu_pkg::FLAG_CMP, 1'b1);
		repeat (3) tick();
		check(o_carry[0], 1'b1); // flag holds
		flag(rsu_pkg::FLAG_CMP, 1'b0);
	endtask

	initial begin
		for (int i = 0; i < NC; i++) begin
			i_flag_op[i] = rsu_pkg::FLAG_NONE;
		end
		repeat (4) @(posedge i_clk_sys);
		#1;
		i_rst = 1'b0;
		check({o_ack, o_carry, o_id_ack}, 32'h0); // quiet after reset
		s_ident();
		s_stuck();
		s_good();
		s_seed();
		s_bad_seed();
		s_flags();
		complete_run();
	end
endmodule // rsu_top_bench
